//--- inc/scs_pkg.sv
// Constants and types shared by the conversion clock sequencer
// How it works
// [RQ1] Internal oscillator ticks conversions, at least 10.5 MHz
// [RQ2] Oscillator stops in deep power-down or serial-clock source
// [RQ3] Acquisition lasts at least three conversion clocks
// [RQ4] Conversion completes in eighteen conversion clocks
// [RQ5] Optional conversion clock is serial clock halved
// [RQ6] Synchronized strobe gives thirty-six serial clock conversion
// [RQ7] Unsynchronized strobe may add one serial clock period; code waits for the next halved tick, up to two serial clock periods
// [RQ8] Host keeps serial clock period at most 1 us
// [RQ9] Inputs held on array, disconnected during conversion
// [RQ10] Manual channel pick or auto alternate 0 and 1
// [RQ11] Strobe falling edge enters hold and starts conversion
// [RQ12] Auto trigger: three clock acquisition, 21 clock cycle
// [RQ13] Clock source changes only between conversions
// [RQ14] Busy held from start through last conversion clock
package scs_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned OSC_MIN_KHZ = 10500;
  // Ticks per oscillator period, rounded down so the rate is never below the floor
  localparam int unsigned OSC_DIV = (CLK_HZ / 1000) / OSC_MIN_KHZ;
  localparam logic [3:0] OSC_DIV_LAST = 4'(OSC_DIV - 1);
  localparam logic [4:0] CONV_CCLKS = 5'h12;
  localparam logic [4:0] ACQ_CCLKS = 5'h03;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  typedef enum logic {SCS_SRC_OSC, SCS_SRC_SCLK} scs_src_e;
  typedef enum logic {SCS_TRIG_MANUAL, SCS_TRIG_AUTO} scs_trig_e;
  typedef enum logic {SCS_CH_MANUAL, SCS_CH_AUTO} scs_chsel_e;
endpackage

//--- inc/scs_tick_if.sv
// Conversion clock tick between the clock generator and the sequencer
`timescale 1ns/1ps
interface scs_tick_if;
  logic tick;
  logic osc_run;
  modport gen (output tick, output osc_run);
  modport seq (input tick, input osc_run);
endinterface

//--- design/scs_conversion_clock_gen.sv
// Conversion clock tick generator: oscillator divider or serial clock halved
`timescale 1ns/1ps
module scs_conversion_clock_gen (
  // Clock and control
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Configuration and state
  input  wire logic src_req_sclk,
  input  wire logic deep_pd,
  input  wire logic busy,
  // Serial clock, synchronous sample
  input  wire logic sclk,
  // Tick to sequencer
  scs_tick_if.gen  tk
);
  logic [3:0] osc_cnt_q;
  logic       sclk_q;
  logic       half_q;
  logic       src_q;
  logic       osc_run;
  logic       sclk_rise;

  // [RQ2] oscillator stop conditions
  assign osc_run = !deep_pd && (src_q == scs_pkg::SCS_SRC_OSC);
  assign sclk_rise = sclk && !sclk_q;

  // [RQ13] source switch when idle
  always_ff @(posedge clk) begin
    if (rst) begin
      src_q <= scs_pkg::SCS_SRC_OSC;
    end else if (ce && !busy) begin
      src_q <= src_req_sclk;
    end
  end

  // [RQ1] oscillator divider
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_cnt_q <= 4'h0;
    end else if (ce) begin
      // Stopped oscillator restarts from a full period
      if (!osc_run || osc_cnt_q == scs_pkg::OSC_DIV_LAST) begin
        osc_cnt_q <= 4'h0;
      end else begin
        osc_cnt_q <= osc_cnt_q + 4'h1;
      end
    end
  end

  // [RQ5] serial clock halved
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_q <= 1'b0;
      half_q <= 1'b0;
    end else if (ce) begin
      sclk_q <= sclk;
      if (sclk_rise) begin
        half_q <= !half_q;
      end
    end
  end

  always_comb begin
    tk.osc_run = osc_run;
    if (src_q == scs_pkg::SCS_SRC_SCLK) begin
      tk.tick = ce && !deep_pd && sclk_rise && half_q;
    end else begin
      tk.tick = ce && osc_run && (osc_cnt_q == scs_pkg::OSC_DIV_LAST);
    end
  end
endmodule

//--- design/scs_sequencer.sv
// Acquisition and conversion sequencer for the successive-approximation core
`timescale 1ns/1ps
module scs_sequencer (
  // Clock and control
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Configuration
  input  wire logic src_sclk_sel,
  input  wire logic trig_auto,
  input  wire logic chsel_auto,
  input  wire logic chan_manual,
  input  wire logic deep_pd,
  // Pins from host
  input  wire logic sclk,
  input  wire logic convert_strobe_n,
  // Status
  output logic      busy,
  output logic      hold,
  output logic      inputs_connected,
  output logic      channel,
  output logic      osc_running,
  output logic      conversion_clock_tick,
  output logic      conv_done
);
  typedef enum logic [1:0] {SCS_ACQ, SCS_WAIT, SCS_CONV} scs_state_e;

  scs_tick_if tk ();
  scs_state_e state_q;
  logic [4:0] cnt_q;
  logic       strb_q;
  logic       chan_q;
  logic       auto_prev_q;
  logic       busy_q;
  logic       strobe_fall;
  logic       acq_met;

  scs_conversion_clock_gen u_gen (
    .clk          (clk),
    .rst          (rst),
    .ce           (ce),
    .src_req_sclk (src_sclk_sel),
    .deep_pd      (deep_pd),
    .busy         (busy_q),
    .sclk         (sclk),
    .tk           (tk.gen)
  );

  assign strobe_fall = strb_q && !convert_strobe_n;
  // [RQ3] acquisition floor
  assign acq_met = (state_q == SCS_ACQ) && (cnt_q >= scs_pkg::ACQ_CCLKS);

  always_ff @(posedge clk) begin
    if (rst) begin
      strb_q <= 1'b1;
    end else if (ce) begin
      strb_q <= convert_strobe_n;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= SCS_ACQ;
      cnt_q <= scs_pkg::CNT_ZERO;
      busy_q <= 1'b0;
      conv_done <= 1'b0;
    end else if (ce) begin
      conv_done <= 1'b0;
      unique case (state_q)
        SCS_ACQ: begin
          if (tk.tick && cnt_q < scs_pkg::ACQ_CCLKS) begin
            cnt_q <= cnt_q + scs_pkg::CNT_ONE;
          end
          // [RQ11] strobe fall enters hold
          if (trig_auto == scs_pkg::SCS_TRIG_MANUAL && strobe_fall && acq_met) begin
            state_q <= SCS_WAIT;
            busy_q <= 1'b1;
            cnt_q <= scs_pkg::CNT_ZERO;
          // [RQ12] auto start after three clocks
          end else if (trig_auto == scs_pkg::SCS_TRIG_AUTO && acq_met) begin
            state_q <= SCS_WAIT;
            busy_q <= 1'b1;
            cnt_q <= scs_pkg::CNT_ZERO;
          // Third acquisition tick is already aligned, so no wait
          end else if (trig_auto == scs_pkg::SCS_TRIG_AUTO && tk.tick
                       && cnt_q == scs_pkg::ACQ_CCLKS - scs_pkg::CNT_ONE) begin
            state_q <= SCS_CONV;
            busy_q <= 1'b1;
            cnt_q <= scs_pkg::CNT_ZERO;
          end
        end
        // [RQ7] start aligns to next conversion clock
        SCS_WAIT: begin
          if (tk.tick) begin
            state_q <= SCS_CONV;
          end
        end
        SCS_CONV: begin
          if (tk.tick) begin
            // [RQ4] eighteen conversion clocks
            // [RQ6] thirty-six serial clocks when aligned
            if (cnt_q == scs_pkg::CONV_CCLKS - scs_pkg::CNT_ONE) begin
              state_q <= SCS_ACQ;
              cnt_q <= scs_pkg::CNT_ZERO;
              // [RQ14] busy drops after final clock
              busy_q <= 1'b0;
              conv_done <= 1'b1;
            end else begin
              cnt_q <= cnt_q + scs_pkg::CNT_ONE;
            end
          end
        end
      endcase
    end
  end

  // [RQ10] manual or alternating channel
  always_ff @(posedge clk) begin
    if (rst) begin
      chan_q <= 1'b0;
      auto_prev_q <= 1'b1;
    end else if (ce) begin
      auto_prev_q <= chsel_auto;
      if (chsel_auto == scs_pkg::SCS_CH_MANUAL) begin
        chan_q <= chan_manual;
      end else if (!auto_prev_q) begin
        chan_q <= 1'b0;
      end else if (conv_done) begin
        chan_q <= !chan_q;
      end
    end
  end

  // [RQ9] hold and disconnect while busy
  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      hold <= 1'b0;
      inputs_connected <= 1'b1;
      channel <= 1'b0;
      osc_running <= 1'b0;
      conversion_clock_tick <= 1'b0;
    end else if (ce) begin
      busy <= busy_q;
      hold <= busy_q;
      inputs_connected <= !busy_q;
      channel <= chan_q;
      osc_running <= tk.osc_run;
      conversion_clock_tick <= tk.tick;
    end
  end
endmodule

//--- sim/scs_host_model.sv
// Host model: serial clock and convert strobe
`timescale 1ns/1ps
module scs_host_model (
  // Clock and requests
  input  wire logic clk,
  input  wire logic run,
  input  wire logic fire,
  // Pins to the converter
  output logic      sclk,
  output logic      convert_strobe_n
);
  logic [1:0] ph = 2'h0;
  logic [2:0] lo = 3'h0;
  initial sclk = 1'b0;
  // Six clk period, still between runs
  always @(posedge clk) begin
    ph <= (run && ph != 2'h2) ? ph + 2'h1 : 2'h0;
    sclk <= run && (ph == 2'h2 ? !sclk : sclk);
  end
  // Strobe low four clk per request
  always @(posedge clk) lo <= fire ? 3'h4 : lo - 3'(lo != 3'h0);
  assign convert_strobe_n = lo == 3'h0;
endmodule

//--- sim/scs_seq_chk.sv
// Port checks for the conversion sequencer
`timescale 1ns/1ps
module scs_seq_chk (
  // Clock and config
  input wire logic clk,
  input wire logic rst,
  input wire logic src_sclk_sel,
  input wire logic chsel_auto,
  input wire logic deep_pd,
  // Status
  input wire logic busy,
  input wire logic hold,
  input wire logic inputs_connected,
  input wire logic channel,
  input wire logic osc_running,
  input wire logic conversion_clock_tick,
  input wire logic conv_done
);
  logic [5:0] n_q;
  logic       b_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Ticks seen in the current phase
  always_ff @(posedge clk) n_q <= (rst || busy != b_q) ? 6'(conversion_clock_tick)
                                  : n_q + 6'(conversion_clock_tick && n_q != 6'h3F);
  always_ff @(posedge clk) b_q <= busy;
  sequence s_quiet;
    (osc_running && !src_sclk_sel && !deep_pd && !conversion_clock_tick) [*2];
  endsequence
  a_hold_busy: assert property (hold == busy)
    else $error("hold wrong");
  a_inputs_off: assert property (inputs_connected != busy)
    else $error("inputs wrong");
  a_done_drop: assert property (conv_done |=> !busy && !conv_done)
    else $error("busy after done");
  a_busy_stands: assert property (busy && !conv_done |=> busy)
    else $error("busy dropped");
  a_conv_len: assert property (conv_done |-> (n_q + 6'(conversion_clock_tick)) inside {[6'h12:6'h13]})
    else $error("conversion length");
  a_acq_min: assert property ($rose(busy) |-> n_q >= 6'h03)
    else $error("short acquisition");
  a_osc_floor: assert property (conversion_clock_tick ##1 s_quiet |=> conversion_clock_tick || !osc_running)
    else $error("oscillator slow");
  a_osc_stop: assert property (deep_pd [*4] |-> !osc_running)
    else $error("oscillator on");
  a_chan_alt: assert property (conv_done && chsel_auto |=> ##1 channel != $past(channel,2))
    else $error("channel kept");
endmodule
bind scs_sequencer scs_seq_chk chk_u (.*);

//--- sim/tb.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0, rst = 1'b1, src = 1'b0, trg = 1'b0, cha = 1'b0;
  logic        chm = 1'b0, pd = 1'b0, run = 1'b0, fire = 1'b0, sclk, cs_n;
  wire  [6:0]  st;
  logic [31:0] lf = 32'h831E;
  int          error_cnt = 0, compares = 0, n;
  always #12.5 clk = !clk;
  scs_host_model host_u (.clk(clk), .run(run), .fire(fire), .sclk(sclk),
    .convert_strobe_n(cs_n));
  scs_sequencer dut_u (.clk(clk), .rst(rst), .ce(1'b1), .src_sclk_sel(src), .trig_auto(trg),
    .chsel_auto(cha), .chan_manual(chm), .deep_pd(pd), .sclk(sclk), .convert_strobe_n(cs_n),
    .busy(st[6]), .hold(st[5]), .inputs_connected(st[4]), .channel(st[3]),
    .osc_running(st[2]), .conversion_clock_tick(st[1]), .conv_done(st[0]));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [7:0] in_rng(input int v, input int lo, input int hi);
    return 8'(v >= lo && v <= hi);
  endfunction
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic conv(input logic f, input int b, output int l);
    @(posedge clk) fire <= f;
    l = 0;
    for (n = 0; n < b && st[0] !== 1'b1; n++) begin
      @(posedge clk) fire <= 1'b0;
      #1 l += int'(st[6]);
    end
    @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #1000000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    int   l;
    logic c;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 chk("reset", 8'h10, {1'b0, st});
    $display("reset done");
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      chm <= lf[0];
      repeat (16 + int'(lf[3:1])) @(posedge clk);
      conv(1'b1, 3000, l);
      chk("len", 8'h01, in_rng(l, 51, 60));
      chk("chan", {7'h00, chm}, {7'h00, st[3]});
      $display("manual %0d done", i);
    end
    conv(1'b1, 60, l);
    chk("early", 8'h00, 8'(l));
    $display("early done");
    trg <= 1'b1;
    cha <= 1'b1;
    conv(1'b0, 3000, l);
    for (int i = 0; i < 3; i++) begin
      #1 c = st[3];
      conv(1'b0, 3000, l);
      chk("gap", 8'h01, in_rng(n + 2, 63, 63));
      #1 chk("alt", {7'h00, !c}, {7'h00, st[3]});
    end
    $display("auto done");
    trg <= 1'b0;
    cha <= 1'b0;
    src <= 1'b1;
    run <= 1'b1;
    repeat (60) @(posedge clk);
    conv(1'b1, 3000, l);
    chk("sclk len", 8'h01, in_rng(l, 204, 240));
    chk("osc off", 8'h00, {7'h00, st[2]});
    $display("sclk done");
    src <= 1'b0;
    pd <= 1'b1;
    repeat (8) @(posedge clk);
    chk("pd osc", 8'h00, {7'h00, st[2]});
    pd <= 1'b0;
    repeat (8) @(posedge clk);
    chk("osc on", 8'h01, {7'h00, st[2]});
    $display("power done");
    tally_and_finish();
  end
endmodule
